// ### hw/mcrb_cfg.svh
`ifndef MCRB_CFG_SVH
`define MCRB_CFG_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define MCRB_OFS_RLT 8'h00
`define MCRB_OFS_EDGE 8'h04
`define MCRB_OFS_PU 8'h08
`define MCRB_OFS_CLK 8'h0C
`define MCRB_OFS_CAR 8'h10
`define MCRB_OFS_CTL 8'h14
`define MCRB_OFS_STAT 8'h18
`define MCRB_OFS_TCLR 8'h1C
`define MCRB_OFS_IST 8'h20
`define MCRB_OFS_IMSK 8'h24
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define MCRB_RST_RLT 2'h0
`define MCRB_RST_EDGE 4'h0
`define MCRB_RST_PU 4'h0
`define MCRB_RST_CLK 4'h8
`define MCRB_RST_CAR 4'h7
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define MCRB_RLT_RUN 0
`define MCRB_RLT_SRC 1
`define MCRB_EDGE_SEL 2
`define MCRB_CLK_SUB 0
`define MCRB_CLK_MAINSTOP 1
`define MCRB_CLK_SUBRUN 2
`define MCRB_CLK_DIV4 3
`define MCRB_CTL_EXTEN 0
`define MCRB_CTL_CR 1
`define MCRB_IRQ_EXT 0
`define MCRB_IRQ_TMR 1
`endif

// ### hw/mcrb_pkg.sv
package mcrb_pkg;
  // carrier selection code
  typedef logic [3:0] mcrb_code_type;
  // system clock steering outputs, all straight from flops
  typedef struct packed {
    logic div4;         // 1: selected oscillator divided by four
    logic src_sub;      // 1: sub oscillator, 0: main oscillator
    logic sub_osc_run;  // sub oscillator running
    logic port67_sel;   // output ports six and seven own the pins
    logic main_osc_run; // main oscillator running
  } mcrb_clkctl_type;
endpackage : mcrb_pkg

// ### hw/mcrb_carrier.sv
`timescale 1ns/1ns
`include "mcrb_cfg.svh"
module mcrb_carrier (
  input wire logic clk,                   // system clock
  input wire logic nrst,                  // async reset, active low
  input wire logic ce,                    // clock enable
  input wire logic run,                   // carrier generating flag
  input wire mcrb_pkg::mcrb_code_type code, // carrier selection code
  output logic wave                       // carrier output
);
  import mcrb_pkg::*;
  logic [4:0] per;     // period in clocks, zero means no wave
  logic [4:0] hi;      // high clocks per period
  logic [4:0] cnt_r;   // phase counter
  logic [4:0] cnt_nxt;
  logic wave_r;
  logic wave_nxt;
  // ---------------------------------------------------------------
  // frequency and duty table
  // ---------------------------------------------------------------
  always_comb begin
    case (code)
      4'h0: begin per = 5'd24; hi = 5'd8; end
      4'h1: begin per = 5'd24; hi = 5'd12; end
      4'h2: begin per = 5'd16; hi = 5'd4; end
      4'h3: begin per = 5'd16; hi = 5'd8; end
      4'h4: begin per = 5'd2; hi = 5'd1; end
      4'h8: begin per = 5'd12; hi = 5'd4; end
      4'h9: begin per = 5'd12; hi = 5'd6; end
      4'hA: begin per = 5'd8; hi = 5'd2; end
      4'hB: begin per = 5'd8; hi = 5'd4; end
      // a flop cannot follow the clock itself: fastest form it can give
      4'hC: begin per = 5'd2; hi = 5'd1; end
      // no wave, reserved and fixed low codes all park low
      default: begin per = 5'd0; hi = 5'd0; end
    endcase
  end
  // ---------------------------------------------------------------
  // phase counter, high while phase is below the high count
  // ---------------------------------------------------------------
  always_comb begin
    if (!run || per == 5'd0 || cnt_r >= per - 5'd1) begin
      cnt_nxt = 5'd0;
    end else begin
      cnt_nxt = cnt_r + 5'd1;
    end
    wave_nxt = run && (per != 5'd0) && (cnt_nxt < hi);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 5'd0;
      wave_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      wave_r <= wave_nxt;
    end
  end
  assign wave = wave_r;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_CAR_LOW: assert property ((code == 4'h7 && ce) |=> !wave)
    else $error("fixed low code drove carrier high");
  AST_CAR_HALF: assert property (
    (run && code == 4'h4 && ce) ##1 (run && code == 4'h4 && ce && wave) |=> !wave)
    else $error("half rate carrier did not alternate");
endmodule : mcrb_carrier

// ### hw/mcrb_top.sv
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "mcrb_cfg.svh"
module mcrb_top (
  input wire logic CLK_SYS,           // system clock, 100 MHz
  input wire logic NRST,              // async reset, active low
  input wire logic CE,                // clock enable, freezes all state
  input wire logic HSEL,              // ahb select
  input wire logic [7:0] HADDR,       // ahb byte address
  input wire logic [1:0] HTRANS,      // ahb transfer type
  input wire logic HWRITE,            // ahb write
  input wire logic [2:0] HSIZE,       // ahb size, word only
  input wire logic [31:0] HWDATA,     // ahb write data
  input wire logic HREADY,            // ahb bus ready
  output logic [31:0] HRDATA,         // ahb read data
  output logic HREADYOUT,             // ahb slave ready
  output logic HRESP,                 // ahb response, always okay
  input wire logic INT_PIN,           // external event pin
  input wire logic TMR2_BIT3,         // bit 3 of the 14-bit timer
  input wire logic PWR_DOWN,          // power-down mode, same clock
  output logic [3:0] PULLUP_EN,       // port one pull-up enables
  output logic [3:0] WAKEUP_EN,       // port one key-on wakeup enables
  output mcrb_pkg::mcrb_clkctl_type CLK_CTRL, // oscillator steering
  output logic [3:0] TMR_COUNT,       // reload timer count
  output logic TMR_UFLOW,             // reload timer underflow pulse
  output logic EXT_IRQ,               // external interrupt request
  output logic CARRIER_OUT,           // carrier wave
  output logic IRQ                    // block interrupt, level
);
  import mcrb_pkg::*;
  // ---------------------------------------------------------------
  // bus slave state
  // ---------------------------------------------------------------
  logic dp_wr_r;          // data phase write pending
  logic dp_wr_nxt;
  logic [7:0] dp_addr_r;  // data phase address
  logic [7:0] dp_addr_nxt;
  logic [31:0] rdata_r;   // read data, loaded in address phase
  logic [31:0] rdata_nxt;
  logic rd_tclr;          // read of the flag test-and-clear register
  logic acc;              // address phase taken
  // only whole word transfers are taken; other sizes are ignored
  assign acc = HSEL && HTRANS[1] && HREADY && CE && HSIZE == 3'b010;
  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [1:0] rlt_r;      // reload_timer_control
  logic [1:0] rlt_nxt;
  logic [3:0] edge_r;     // external_edge_control
  logic [3:0] edge_nxt;
  logic [3:0] pu_r;       // port_pullup_wakeup_control
  logic [3:0] pu_nxt;
  logic [3:0] clk_r;      // clock_mode_control
  logic [3:0] clk_nxt;
  logic [3:0] car_r;      // carrier_select, write only
  logic [3:0] car_nxt;
  logic [7:0] ctl_r;      // enable, generating flag, reload value
  logic [7:0] ctl_nxt;
  logic [1:0] ist_r;      // sticky interrupt status
  logic [1:0] ist_nxt;
  logic [1:0] imsk_r;     // interrupt mask
  logic [1:0] imsk_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [3:0] pullup_r;   // pin copies keep outputs flop driven
  logic [3:0] wake_r;
  mcrb_clkctl_type cc_r;
  mcrb_clkctl_type cc_nxt;
  logic wr;               // data phase write strobe
  assign wr = dp_wr_r && CE;
  // ---------------------------------------------------------------
  // external pin and flag state
  // ---------------------------------------------------------------
  logic pin_m_r;          // synchroniser first stage
  logic pin_s_r;          // synchroniser second stage
  logic act_d_r;          // previous active level
  logic act;              // pin at its active level
  logic act_rise;         // valid edge seen
  logic ext_flag_r;       // external_request_flag
  logic ext_flag_nxt;
  logic ext_irq_r;
  logic ext_irq_nxt;
  // ---------------------------------------------------------------
  // reload timer state
  // ---------------------------------------------------------------
  logic t2_d_r;           // previous tick source level
  logic tick;             // count strobe
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic uf_r;
  logic uf_nxt;
  logic car_wave;
  // ---------------------------------------------------------------
  // address phase: latch and prepare read data
  // ---------------------------------------------------------------
  always_comb begin
    dp_wr_nxt = acc && HWRITE;
    dp_addr_nxt = acc ? HADDR : dp_addr_r;
    rdata_nxt = 32'h0000_0000;
    rd_tclr = 1'b0;
    if (acc && !HWRITE) begin
      if (HADDR == `MCRB_OFS_RLT) begin
        rdata_nxt[1:0] = rlt_r;
      end else if (HADDR == `MCRB_OFS_EDGE) begin
        rdata_nxt[3:0] = edge_r;
      end else if (HADDR == `MCRB_OFS_PU) begin
        rdata_nxt[3:0] = pu_r;
      end else if (HADDR == `MCRB_OFS_CLK) begin
        rdata_nxt[3:0] = clk_r;
      end else if (HADDR == `MCRB_OFS_CTL) begin
        rdata_nxt[7:0] = ctl_r;
      end else if (HADDR == `MCRB_OFS_STAT) begin
        rdata_nxt[0] = ext_flag_r;
        rdata_nxt[1] = act;
        rdata_nxt[7:4] = cnt_r;
      end else if (HADDR == `MCRB_OFS_TCLR) begin
        // test only works while the external interrupt is disabled
        rdata_nxt[0] = ext_flag_r && !ctl_r[`MCRB_CTL_EXTEN];
        rd_tclr = !ctl_r[`MCRB_CTL_EXTEN];
      end else if (HADDR == `MCRB_OFS_IST) begin
        rdata_nxt[1:0] = ist_r;
      end else if (HADDR == `MCRB_OFS_IMSK) begin
        rdata_nxt[1:0] = imsk_r;
      end else begin
        rdata_nxt = 32'h0000_0000; // unmapped and carrier select read zero
      end
    end
  end
  // slave state is frozen with the rest of the block
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end else if (CE) begin
      dp_wr_r <= dp_wr_nxt;
      dp_addr_r <= dp_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  // ---------------------------------------------------------------
  // register writes in the data phase
  // ---------------------------------------------------------------
  always_comb begin
    rlt_nxt = rlt_r;
    edge_nxt = edge_r;
    pu_nxt = pu_r;
    clk_nxt = clk_r;
    car_nxt = car_r;
    ctl_nxt = ctl_r;
    imsk_nxt = imsk_r;
    if (wr) begin
      if (dp_addr_r == `MCRB_OFS_RLT) begin
        rlt_nxt = HWDATA[1:0];
      end else if (dp_addr_r == `MCRB_OFS_EDGE) begin
        edge_nxt = HWDATA[3:0];
      end else if (dp_addr_r == `MCRB_OFS_PU) begin
        pu_nxt = HWDATA[3:0];
      end else if (dp_addr_r == `MCRB_OFS_CLK) begin
        clk_nxt = HWDATA[3:0];
      end else if (dp_addr_r == `MCRB_OFS_CAR) begin
        car_nxt = HWDATA[3:0];
      end else if (dp_addr_r == `MCRB_OFS_CTL) begin
        ctl_nxt = HWDATA[7:0];
      end else if (dp_addr_r == `MCRB_OFS_IMSK) begin
        imsk_nxt = HWDATA[1:0];
      end
    end
    // power-down restores only the carrier pair; the rest is kept
    if (PWR_DOWN) begin
      car_nxt = `MCRB_RST_CAR;
      ctl_nxt[`MCRB_CTL_CR] = 1'b0;
    end
    // decoded oscillator steering, registered beside the raw bits
    cc_nxt.div4 = clk_nxt[`MCRB_CLK_DIV4];
    cc_nxt.src_sub = clk_nxt[`MCRB_CLK_SUB];
    cc_nxt.sub_osc_run = clk_nxt[`MCRB_CLK_SUBRUN];
    cc_nxt.port67_sel = !clk_nxt[`MCRB_CLK_SUBRUN];
    cc_nxt.main_osc_run = !clk_nxt[`MCRB_CLK_MAINSTOP];
  end
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rlt_r <= `MCRB_RST_RLT;
      edge_r <= `MCRB_RST_EDGE;
      pu_r <= `MCRB_RST_PU;
      clk_r <= `MCRB_RST_CLK;
      car_r <= `MCRB_RST_CAR;
      ctl_r <= 8'h00;
      imsk_r <= 2'b00;
      pullup_r <= `MCRB_RST_PU;
      wake_r <= `MCRB_RST_PU;
      cc_r <= '{div4: 1'b1, src_sub: 1'b0, sub_osc_run: 1'b0,
                port67_sel: 1'b1, main_osc_run: 1'b1};
    end else if (CE) begin
      rlt_r <= rlt_nxt;
      edge_r <= edge_nxt;
      pu_r <= pu_nxt;
      clk_r <= clk_nxt;
      car_r <= car_nxt;
      ctl_r <= ctl_nxt;
      imsk_r <= imsk_nxt;
      pullup_r <= pu_nxt;
      wake_r <= pu_nxt;
      cc_r <= cc_nxt;
    end
  end
  // ---------------------------------------------------------------
  // external event pin: sync, valid edge, request flag
  // ---------------------------------------------------------------
  // active level follows the edge bit, so flipping the bit while the
  // pin sits at the new active level looks like an edge and sets the flag
  assign act = edge_r[`MCRB_EDGE_SEL] ? pin_s_r : !pin_s_r;
  assign act_rise = act && !act_d_r;
  always_comb begin
    ext_flag_nxt = ext_flag_r;
    if (acc && !HWRITE && rd_tclr) begin
      ext_flag_nxt = 1'b0;
    end
    if (act_rise) begin
      ext_flag_nxt = 1'b1; // set wins over the clear
    end
    ext_irq_nxt = ext_flag_nxt && ctl_nxt[`MCRB_CTL_EXTEN];
  end
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pin_m_r <= 1'b0;
      pin_s_r <= 1'b0;
      act_d_r <= 1'b1;
      ext_flag_r <= 1'b0;
      ext_irq_r <= 1'b0;
    end else if (CE) begin
      pin_m_r <= INT_PIN;
      pin_s_r <= pin_m_r;
      act_d_r <= act;
      ext_flag_r <= ext_flag_nxt;
      ext_irq_r <= ext_irq_nxt;
    end
  end
  // ---------------------------------------------------------------
  // four-bit reload timer
  // ---------------------------------------------------------------
  // divided source counts on the rising edge of the timer tap
  assign tick = rlt_r[`MCRB_RLT_SRC] ? 1'b1 : (TMR2_BIT3 && !t2_d_r);
  always_comb begin
    cnt_nxt = cnt_r;
    uf_nxt = 1'b0;
    if (rlt_r[`MCRB_RLT_RUN] && tick) begin
      if (cnt_r == 4'h0) begin
        cnt_nxt = ctl_r[7:4];
        uf_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
    end
  end
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      t2_d_r <= 1'b0;
      cnt_r <= 4'h0;
      uf_r <= 1'b0;
    end else if (CE) begin
      t2_d_r <= TMR2_BIT3;
      cnt_r <= cnt_nxt;
      uf_r <= uf_nxt;
    end
  end
  // ---------------------------------------------------------------
  // sticky status, write one to clear, masked level interrupt
  // ---------------------------------------------------------------
  always_comb begin
    ist_nxt = ist_r;
    if (wr && dp_addr_r == `MCRB_OFS_IST) begin
      ist_nxt = ist_r & ~HWDATA[1:0];
    end
    // events after the clear so a same-cycle event survives
    if (act_rise) begin
      ist_nxt[`MCRB_IRQ_EXT] = 1'b1;
    end
    if (uf_nxt) begin
      ist_nxt[`MCRB_IRQ_TMR] = 1'b1;
    end
    irq_nxt = |(ist_nxt & imsk_nxt);
  end
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ist_r <= 2'b00;
      irq_r <= 1'b0;
    end else if (CE) begin
      ist_r <= ist_nxt;
      irq_r <= irq_nxt;
    end
  end
  // ---------------------------------------------------------------
  // carrier generator
  // ---------------------------------------------------------------
  mcrb_carrier u_carrier (
    .clk (CLK_SYS),
    .nrst (NRST),
    .ce (CE),
    .run (ctl_r[`MCRB_CTL_CR]),
    .code (car_r),
    .wave (car_wave)
  );
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign HRDATA = rdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign PULLUP_EN = pullup_r;
  assign WAKEUP_EN = wake_r;
  assign CLK_CTRL = cc_r;
  assign TMR_COUNT = cnt_r;
  assign TMR_UFLOW = uf_r;
  assign EXT_IRQ = ext_irq_r;
  assign CARRIER_OUT = car_wave;
  assign IRQ = irq_r;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  AST_TMR_HOLD: assert property ((CE && !rlt_r[`MCRB_RLT_RUN]) |=> $stable(cnt_r))
    else $error("stopped timer changed its count");
  AST_TMR_FAST: assert property (
    (CE && rlt_r == 2'b11 && cnt_r != 4'h0) |=> cnt_r == $past(cnt_r) - 4'h1)
    else $error("clock sourced timer missed a count");
  AST_EDGE_FLAG: assert property ((CE && act && !act_d_r) |=> ext_flag_r)
    else $error("valid edge did not set the request flag");
  AST_EDGE_SEL: assert property (
    (CE && !edge_r[`MCRB_EDGE_SEL] && pin_s_r) ##1 (CE && !pin_s_r
      && !edge_r[`MCRB_EDGE_SEL]) |=> ext_flag_r)
    else $error("falling edge lost with falling edge selected");
  AST_RSV_BITS: assert property (
    (wr && dp_addr_r == `MCRB_OFS_EDGE && !PWR_DOWN) |=> edge_r == $past(HWDATA[3:0]))
    else $error("edge register did not keep written bits");
  AST_PULLUP: assert property ((CE && wr && dp_addr_r == `MCRB_OFS_PU)
    |=> PULLUP_EN == $past(HWDATA[3:0]) && WAKEUP_EN == PULLUP_EN)
    else $error("pull-up and wakeup enables disagree with write");
  AST_OSC: assert property (CLK_CTRL.main_osc_run == !clk_r[`MCRB_CLK_MAINSTOP]
    && CLK_CTRL.port67_sel == !CLK_CTRL.sub_osc_run)
    else $error("oscillator steering disagrees with clock mode");
  AST_CAR_OFF: assert property ((CE && !ctl_r[`MCRB_CTL_CR]) |=> !CARRIER_OUT)
    else $error("carrier high while generation stopped");
  AST_TEST_DIS: assert property (
    (acc && !HWRITE && HADDR == `MCRB_OFS_TCLR && ctl_r[`MCRB_CTL_EXTEN]
      && ext_flag_r) |=> ext_flag_r)
    else $error("flag test cleared flag while interrupt enabled");
  AST_PWRDN: assert property ((CE && PWR_DOWN) |=> car_r == `MCRB_RST_CAR
    && $stable(clk_r) && $stable(pu_r))
    else $error("power-down disturbed retained registers");
endmodule : mcrb_top

// ### sim/mcrb_top_bench.sv
`timescale 1ns/1ns
`include "mcrb_cfg.svh"
module mcrb_top_bench;
  import mcrb_pkg::*;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic clk_sys, nrst, hsel, hwrite, hready, int_pin, tmr2_bit3, pwr_down, ce; // stimulus
  logic [7:0] haddr; // byte address
  logic [1:0] htrans; // transfer type
  logic [2:0] hsize; // word, except one byte-sized write
  logic [31:0] hwdata, hrdata, v; // bus data and scratch
  logic hreadyout, hresp, tmr_uflow, ext_irq, carrier_out, irq, rd_phase, prev; // observed
  logic [3:0] pullup_en, wakeup_en, tmr_count, div_cnt; // div_cnt makes the tap
  mcrb_clkctl_type clk_ctrl; // oscillator steering
  int err_count, samples_checked, seed, n, hi, rise; // counters
  logic [31:0] exp_q[$], msk_q[$]; // expected read data and care mask
  mcrb_top DUT (.CLK_SYS(clk_sys), .NRST(nrst), .CE(ce), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .INT_PIN(int_pin),
    .TMR2_BIT3(tmr2_bit3), .PWR_DOWN(pwr_down), .PULLUP_EN(pullup_en), .WAKEUP_EN(wakeup_en),
    .CLK_CTRL(clk_ctrl), .TMR_COUNT(tmr_count), .TMR_UFLOW(tmr_uflow), .EXT_IRQ(ext_irq),
    .CARRIER_OUT(carrier_out), .IRQ(irq));
  assign hready = hreadyout; // single slave owns the bus ready
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // tap of the 14-bit timer: one rising edge every 16 cycles
  always @(posedge clk_sys) begin
    div_cnt <= div_cnt + 4'h1;
    tmr2_bit3 <= div_cnt[3];
  end
  // ----------------------------------------------------------
  // checking
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // monitor: read data stands in the data phase only, so take it at that edge
  always @(posedge clk_sys) begin
    if (rd_phase && hreadyout === 1'b1) begin
      check(hrdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  task final_report;
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------------------------
  // bus master
  // ----------------------------------------------------------
  // bounded wait for ready; a hang ends the run rather than stalling it
  task wait_rdy;
    int k;
    k = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1 && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 50) begin
      err_count++;
      final_report;
    end
  endtask : wait_rdy
  task addr_ph(input logic [7:0] a, input logic w);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
  endtask : addr_ph
  task wr(input logic [7:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    wait_rdy;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    addr_ph(a, 1'b0);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    rd_phase <= 1'b1;
    wait_rdy;
    rd_phase <= 1'b0;
  endtask : rd
  // cycles between two underflow pulses; sampled at the falling edge where settled
  task per_uflow(output int p);
    p = 0;
    do @(negedge clk_sys); while (tmr_uflow !== 1'b1 && ++p < 500);
    p = 0;
    do begin @(negedge clk_sys); p++; end while (tmr_uflow !== 1'b1 && p < 500);
    @(posedge clk_sys);
  endtask : per_uflow
  // 48 cycles span a whole number of every carrier period
  task meas(output int h, output int r);
    @(negedge clk_sys);
    prev = carrier_out;
    h = 0;
    r = 0;
    repeat (48) begin
      if (prev === 1'b1) h++;
      @(negedge clk_sys);
      if (carrier_out === 1'b1 && prev === 1'b0) r++;
      prev = carrier_out;
    end
    @(posedge clk_sys);
  endtask : meas
  // high cycles and rising edges per 48 cycles for each code
  function automatic logic [15:0] car_exp(input logic [3:0] c);
    case (c)
      4'h0: return 16'h1002;
      4'h1: return 16'h1802;
      4'h2: return 16'h0C03;
      4'h3: return 16'h1803;
      4'h4, 4'hC: return 16'h1818;
      4'h8: return 16'h1004;
      4'h9: return 16'h1804;
      4'hA: return 16'h0C06;
      4'hB: return 16'h1806;
      default: return 16'h0000; // no wave or held low
    endcase
  endfunction : car_exp
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  initial begin
    seed = 32'h18e7;
    {err_count, samples_checked} = 0;
    {nrst, hsel, htrans, haddr, hwrite, hwdata, tmr2_bit3, pwr_down, rd_phase} = 0;
    {ce, hsize, int_pin, div_cnt} = 9'h151;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(`MCRB_OFS_RLT, 32'h0, 32'hFFFF_FFFF);
    rd(`MCRB_OFS_EDGE, 32'h0, 32'hFFFF_FFFF);
    rd(`MCRB_OFS_PU, 32'h0, 32'hFFFF_FFFF);
    rd(`MCRB_OFS_CLK, 32'h8, 32'hFFFF_FFFF);
    rd(`MCRB_OFS_CAR, 32'h0, 32'hFFFF_FFFF);
    @(negedge clk_sys);
    check(clk_ctrl, 32'h13);
    for (n = 0; n < 6; n++) begin
      v = $random(seed);
      wr(`MCRB_OFS_RLT, v);
      wr(`MCRB_OFS_EDGE, v);
      wr(`MCRB_OFS_PU, v);
      wr(`MCRB_OFS_CLK, v);
      wr(8'h40, v);
      rd(`MCRB_OFS_RLT, v, 32'hFFFF_FFFF & 32'h3);
      rd(`MCRB_OFS_EDGE, v & 32'hF, 32'hFFFF_FFFF);
      rd(`MCRB_OFS_PU, v & 32'hF, 32'hFFFF_FFFF);
      rd(`MCRB_OFS_CLK, v & 32'hF, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0, 32'hFFFF_FFFF);
      @(negedge clk_sys);
      check({pullup_en, wakeup_en}, {v[3:0], v[3:0]});
      check(clk_ctrl, {v[3], v[0], v[2], ~v[2], ~v[1]});
      @(posedge clk_sys);
    end
    // a byte-sized write must be ignored, so the pull-up value below is unchanged
    hsize <= 3'h0;
    wr(`MCRB_OFS_PU, ~v);
    hsize <= 3'h2;
    pwr_down <= 1'b1;
    @(posedge clk_sys);
    pwr_down <= 1'b0;
    rd(`MCRB_OFS_PU, v & 32'hF, 32'hFFFF_FFFF);
    rd(`MCRB_OFS_CLK, v & 32'hF, 32'hFFFF_FFFF);
    rd(`MCRB_OFS_EDGE, v & 32'hF, 32'hFFFF_FFFF);
    wr(`MCRB_OFS_CTL, 32'h50);
    wr(`MCRB_OFS_RLT, 32'h3);
    per_uflow(n);
    check(n, 32'h6);
    wr(`MCRB_OFS_RLT, 32'h1);
    per_uflow(n);
    check(n, 32'h60);
    // clock enable low freezes the running timer
    ce <= 1'b0;
    @(negedge clk_sys);
    v = tmr_count;
    repeat (40) @(negedge clk_sys);
    check(tmr_count, v);
    @(posedge clk_sys);
    ce <= 1'b1;
    wr(`MCRB_OFS_RLT, 32'h0);
    @(negedge clk_sys);
    v = tmr_count;
    repeat (40) @(negedge clk_sys);
    check(tmr_count, v);
    @(posedge clk_sys);
    wr(`MCRB_OFS_EDGE, 32'h0);
    repeat (5) @(posedge clk_sys);
    rd(`MCRB_OFS_TCLR, 32'h0, 32'h0);
    wr(`MCRB_OFS_EDGE, 32'h4);
    repeat (3) @(posedge clk_sys);
    rd(`MCRB_OFS_TCLR, 32'h1, 32'h1);
    rd(`MCRB_OFS_TCLR, 32'h0, 32'h1);
    rd(`MCRB_OFS_STAT, 32'h2, 32'h2);
    wr(`MCRB_OFS_EDGE, 32'h0);
    repeat (3) @(posedge clk_sys);
    rd(`MCRB_OFS_TCLR, 32'h0, 32'h1);
    rd(`MCRB_OFS_STAT, 32'h0, 32'h2);
    int_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rd(`MCRB_OFS_TCLR, 32'h1, 32'h1);
    rd(`MCRB_OFS_STAT, 32'h2, 32'h2);
    int_pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(`MCRB_OFS_TCLR, 32'h0, 32'h1);
    wr(`MCRB_OFS_IST, 32'h3);
    wr(`MCRB_OFS_IMSK, 32'h0);
    wr(`MCRB_OFS_CTL, 32'h1);
    int_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rd(`MCRB_OFS_TCLR, 32'h0, 32'h1);
    rd(`MCRB_OFS_IST, 32'h1, 32'h1);
    @(negedge clk_sys);
    check({ext_irq, irq}, 32'h2);
    @(posedge clk_sys);
    wr(`MCRB_OFS_IMSK, 32'h1);
    @(negedge clk_sys);
    check(irq, 32'h1);
    @(posedge clk_sys);
    wr(`MCRB_OFS_IST, 32'h1);
    @(negedge clk_sys);
    check(irq, 32'h0);
    @(posedge clk_sys);
    for (n = 0; n < 16; n++) begin
      if (n != 6 && n != 14) begin
        wr(`MCRB_OFS_CAR, n);
        wr(`MCRB_OFS_CTL, 32'h2);
        repeat (30) @(posedge clk_sys);
        meas(hi, rise);
        check({hi[7:0], rise[7:0]}, car_exp(n[3:0]));
      end
    end
    wr(`MCRB_OFS_CAR, 32'hB);
    wr(`MCRB_OFS_CTL, 32'h0);
    repeat (3) @(posedge clk_sys);
    meas(hi, rise);
    check(hi, 32'h0);
    wr(`MCRB_OFS_CTL, 32'h2);
    pwr_down <= 1'b1;
    @(posedge clk_sys);
    pwr_down <= 1'b0;
    repeat (3) @(posedge clk_sys);
    meas(hi, rise);
    check(hi, 32'h0);
    final_report;
  end
endmodule : mcrb_top_bench
